// File: hdl/sbm_pkg.sv
// Shared constants and types of the sync bus mailbox block.
package sbm_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SAMPLE_PERIOD_NS = 2000000;
	localparam int SAMPLE_CYC = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BIT_NS_1M = 1000;
	localparam int BIT_NS_500K = 2000;
	localparam int BIT_NS_250K = 4000;
	localparam int BIT_CYC_1M = BIT_NS_1M / CLK_PERIOD_NS;
	localparam int BIT_CYC_500K = BIT_NS_500K / CLK_PERIOD_NS;
	localparam int BIT_CYC_250K = BIT_NS_250K / CLK_PERIOD_NS;
	localparam int BIT_CNT_W = 10;

	localparam int MAX_NODES = 16;
	localparam int NUM_MBX = 8;
	localparam int ID_W = 11;
	localparam int DATA_W = 32;
	localparam logic [ID_W-1:0] ID_MIN = 11'h001;
	localparam logic [ID_W-1:0] ID_MAX = 11'h7ff;
	localparam logic [ID_W-1:0] SYNC_ID = 11'h000;

	localparam logic [1:0] RATE_1M = 2'h0;
	localparam logic [1:0] RATE_500K = 2'h1;
	localparam logic [1:0] RATE_250K = 2'h2;
	localparam logic [1:0] RATE_BAD = 2'h3;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SYNC_CFG = 8'h08;
	localparam logic [7:0] OFS_MTX_WORD = 8'h0c;
	localparam logic [7:0] OFS_SRX_WORD = 8'h10;
	localparam logic [7:0] OFS_TX_ID = 8'h14;
	localparam logic [7:0] OFS_TX_DATA = 8'h18;
	localparam logic [7:0] OFS_MBX_PROG = 8'h1c;
	localparam logic [7:0] OFS_MBX_FLAG = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
	localparam logic [2:0] OFS_MBX_DATA_HI = 3'h2;

	localparam int CTRL_ROLE_BIT = 0;
	localparam int CTRL_SYNC_EN_BIT = 1;
	localparam int CTRL_RATE_LSB = 2;
	localparam int STAT_IDLE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_NOVM_BIT = 2;
	localparam int MBXP_BOX_LSB = 12;

	localparam int NUM_EV = 5;
	localparam int EV_SYNC_RX = 0;
	localparam int EV_SYNC_TX = 1;
	localparam int EV_MBX_RX = 2;
	localparam int EV_TX_DONE = 3;
	localparam int EV_TX_REJ = 4;

	localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
	localparam logic [NUM_EV-1:0] EV_RST = 5'h00;

	typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_USER} sbm_tx_t;
endpackage

// File: hdl/sbm_rx_if.sv
// Received frame as seen by the mailboxes.
`timescale 1ns/1ps
interface sbm_rx_if import sbm_pkg::*; ();
	logic valid;
	logic [ID_W-1:0] id;
	logic [DATA_W-1:0] data;
	modport src (output valid, output id, output data);
	modport mbx (input valid, input id, input data);
endinterface

// File: hdl/sbm_mailbox.sv
// One receive mailbox: identifier filter, payload store and update flag.
`timescale 1ns/1ps
module sbm_mailbox import sbm_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	sbm_rx_if.mbx rx,
	input wire logic prog_we,
	input wire logic [ID_W-1:0] prog_id,
	input wire logic flag_clr,
	output logic [DATA_W-1:0] data,
	output logic flag,
	output logic hit
);
	logic [ID_W-1:0] id_r;
	logic en_r;
	logic [DATA_W-1:0] data_r;
	logic flag_r;

	assign hit = en_r && rx.valid && (rx.id == id_r);
	assign data = data_r;
	assign flag = flag_r;

	// Identifier zero cannot be programmed, so it leaves the mailbox disabled.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			id_r <= SYNC_ID;
			en_r <= 1'b0;
		end else if (prog_we) begin
			id_r <= prog_id;
			en_r <= (prog_id >= ID_MIN) && (prog_id <= ID_MAX);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_r <= WORD_RST;
		end else if (hit) begin
			data_r <= rx.data;
		end
	end

	// A frame landing in the clearing cycle keeps the flag set.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_r <= 1'b0;
		end else if (hit) begin
			flag_r <= 1'b1;
		end else if (flag_clr) begin
			flag_r <= 1'b0;
		end
	end
endmodule

// File: hdl/sbm_top.sv
// Sync bus mailbox: AHB-Lite registers, sync broadcast, frame send and receive mailboxes.
// Behaviour
// - Up to sixteen cards share the sync bus and exactly one of them is the master.
// - With sync active the master sends each sampling period a sync frame with one position word.
// - The role command makes the card master with value 1 and slave with value 0.
// - The broadcast word is readable as master_tx_word and the received one as slave_rx_word.
// - A write to sync_config_word takes effect only while the trajectory planner is idle.
// - Frame send transmits the given data with the given identifier, valid only from 1 to 2047.
// - Mailbox programming sets mailbox 0 to 7 to accept one identifier from 1 to 2047.
// - The payload of an accepted frame is stored in the data entry of its mailbox.
// - Each mailbox that receives new data sets its own bit of the update flag word.
// - Rate code 0, 1 and 2 give 1 Mbps, 500 Kbps and 250 Kbps, and code 2 has no master broadcast.
`timescale 1ns/1ps
module sbm_top import sbm_pkg::*; #(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic planner_idle,
	output logic tx_valid,
	output logic [ID_W-1:0] tx_id,
	output logic [DATA_W-1:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [ID_W-1:0] rx_id,
	input wire logic [DATA_W-1:0] rx_data,
	output logic is_master,
	output logic [1:0] rate_code,
	output logic bit_tick,
	output logic irq
);
	logic dph_r, wr_r, hreadyout_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic take, wr_en, rd_en;
	logic role_r, sync_en_r;
	logic [1:0] rate_r;
	logic [DATA_W-1:0] sync_cfg_r, mtx_word_r, srx_word_r, usr_data_r;
	logic [ID_W-1:0] tx_id_r, usr_id_r;
	logic [NUM_EV-1:0] ev_r, mask_r, ev_set;
	logic irq_r;
	logic [31:0] rdata;
	logic [31:0] samp_cnt_r;
	logic sync_due, usr_req, usr_rej, sync_pend_r, usr_pend_r;
	sbm_tx_t tx_st_r;
	logic tx_valid_r;
	logic [ID_W-1:0] tx_id_o_r;
	logic [DATA_W-1:0] tx_data_o_r;
	logic [BIT_CNT_W-1:0] bit_cnt_r, bit_lim;
	logic bit_tick_r;
	logic sync_hit, tx_hs;
	logic [NUM_MBX-1:0] mbx_we, mbx_clr, mbx_flag, mbx_hit;
	logic [DATA_W-1:0] mbx_data [NUM_MBX];
	logic [2:0] prog_box;

	sbm_rx_if rxb ();

	assign rxb.valid = rx_valid;
	assign rxb.id = rx_id;
	assign rxb.data = rx_data;

	// Bus slave: every transfer gets one wait state so writes land before the next read.
	assign take = hsel && htrans[1] && hready && !dph_r;
	assign wr_en = dph_r && wr_r;
	assign rd_en = dph_r && !wr_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			hreadyout_r <= 1'b1;
		end else if (take) begin
			dph_r <= 1'b1;
			wr_r <= hwrite;
			addr_r <= haddr[7:0];
			hreadyout_r <= 1'b0;
		end else if (dph_r) begin
			dph_r <= 1'b0;
			hreadyout_r <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_en) begin
			hrdata_r <= rdata;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	// Only whole-word transfers occur and every answer is OKAY.
	assign hresp = 1'b0;

	always_comb begin
		rdata = 32'h0000_0000;
		case (addr_r)
			OFS_CTRL: begin
				rdata[CTRL_ROLE_BIT] = role_r;
				rdata[CTRL_SYNC_EN_BIT] = sync_en_r;
				rdata[CTRL_RATE_LSB +: 2] = rate_r;
			end
			OFS_STATUS: begin
				rdata[STAT_IDLE_BIT] = planner_idle;
				rdata[STAT_BUSY_BIT] = usr_pend_r;
				rdata[STAT_NOVM_BIT] = (rate_r == RATE_250K);
			end
			OFS_SYNC_CFG: rdata = sync_cfg_r;
			OFS_MTX_WORD: rdata = mtx_word_r;
			OFS_SRX_WORD: rdata = srx_word_r;
			OFS_TX_ID: rdata[ID_W-1:0] = tx_id_r;
			OFS_MBX_FLAG: rdata[NUM_MBX-1:0] = mbx_flag;
			OFS_IRQ_STAT: rdata[NUM_EV-1:0] = ev_r;
			OFS_IRQ_MASK: rdata[NUM_EV-1:0] = mask_r;
			default: begin
				if (addr_r[7:5] == OFS_MBX_DATA_HI) begin
					rdata = mbx_data[addr_r[4:2]];
				end
			end
		endcase
	end

	// Control word; the unused rate code is refused and the old rate kept.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			role_r <= 1'b0;
			sync_en_r <= 1'b0;
			rate_r <= RATE_1M;
		end else if (wr_en && addr_r == OFS_CTRL) begin
			role_r <= hwdata[CTRL_ROLE_BIT];
			sync_en_r <= hwdata[CTRL_SYNC_EN_BIT];
			if (hwdata[CTRL_RATE_LSB +: 2] != RATE_BAD) begin
				rate_r <= hwdata[CTRL_RATE_LSB +: 2];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_cfg_r <= WORD_RST;
		end else if (wr_en && addr_r == OFS_SYNC_CFG && planner_idle) begin
			sync_cfg_r <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mtx_word_r <= WORD_RST;
			tx_id_r <= SYNC_ID;
		end else if (wr_en) begin
			if (addr_r == OFS_MTX_WORD) begin
				mtx_word_r <= hwdata;
			end
			if (addr_r == OFS_TX_ID) begin
				tx_id_r <= hwdata[ID_W-1:0];
			end
		end
	end

	// Only a slave takes the broadcast; the master ignores echoes of identifier zero.
	assign sync_hit = rx_valid && (rx_id == SYNC_ID) && !role_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			srx_word_r <= WORD_RST;
		end else if (sync_hit) begin
			srx_word_r <= rx_data;
		end
	end

	assign usr_req = wr_en && addr_r == OFS_TX_DATA && !usr_pend_r
		&& tx_id_r >= ID_MIN && tx_id_r <= ID_MAX;
	assign usr_rej = wr_en && addr_r == OFS_TX_DATA && !usr_req;

	// Sampling period timer; a master at the slowest rate broadcasts nothing.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_cnt_r <= 32'h0000_0000;
		end else if (!(role_r && sync_en_r) || samp_cnt_r == 32'(SAMPLE_CYCLES - 1)) begin
			samp_cnt_r <= 32'h0000_0000;
		end else begin
			samp_cnt_r <= samp_cnt_r + 32'h0000_0001;
		end
	end

	assign sync_due = role_r && sync_en_r && rate_r != RATE_250K
		&& samp_cnt_r == 32'(SAMPLE_CYCLES - 1);

	assign tx_hs = tx_valid_r && tx_ready;

	// Transmit engine: a due sync frame goes before a waiting user frame.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st_r <= TX_IDLE;
			tx_valid_r <= 1'b0;
			tx_id_o_r <= SYNC_ID;
			tx_data_o_r <= WORD_RST;
			sync_pend_r <= 1'b0;
			usr_pend_r <= 1'b0;
			usr_id_r <= SYNC_ID;
			usr_data_r <= WORD_RST;
		end else begin
			if (sync_due) begin
				sync_pend_r <= 1'b1;
			end
			if (usr_req) begin
				usr_pend_r <= 1'b1;
				usr_id_r <= tx_id_r;
				usr_data_r <= hwdata;
			end
			case (tx_st_r)
				TX_IDLE: begin
					if (sync_pend_r) begin
						tx_st_r <= TX_SYNC;
						tx_valid_r <= 1'b1;
						tx_id_o_r <= SYNC_ID;
						tx_data_o_r <= mtx_word_r;
					end else if (usr_pend_r) begin
						tx_st_r <= TX_USER;
						tx_valid_r <= 1'b1;
						tx_id_o_r <= usr_id_r;
						tx_data_o_r <= usr_data_r;
					end
				end
				TX_SYNC: begin
					if (tx_hs) begin
						tx_st_r <= TX_IDLE;
						tx_valid_r <= 1'b0;
						sync_pend_r <= sync_due;
					end
				end
				TX_USER: begin
					if (tx_hs) begin
						tx_st_r <= TX_IDLE;
						tx_valid_r <= 1'b0;
						usr_pend_r <= 1'b0;
					end
				end
				default: begin
					tx_st_r <= TX_IDLE;
					tx_valid_r <= 1'b0;
				end
			endcase
		end
	end

	assign tx_valid = tx_valid_r;
	assign tx_id = tx_id_o_r;
	assign tx_data = tx_data_o_r;
	assign is_master = role_r;
	assign rate_code = rate_r;

	// Bit-time strobe for the line driver at the selected rate.
	always_comb begin
		case (rate_r)
			RATE_500K: bit_lim = BIT_CNT_W'(BIT_CYC_500K - 1);
			RATE_250K: bit_lim = BIT_CNT_W'(BIT_CYC_250K - 1);
			default: bit_lim = BIT_CNT_W'(BIT_CYC_1M - 1);
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_cnt_r <= '0;
			bit_tick_r <= 1'b0;
		end else if (bit_cnt_r >= bit_lim) begin
			bit_cnt_r <= '0;
			bit_tick_r <= 1'b1;
		end else begin
			bit_cnt_r <= bit_cnt_r + BIT_CNT_W'(1);
			bit_tick_r <= 1'b0;
		end
	end

	assign bit_tick = bit_tick_r;

	// Mailboxes.
	assign prog_box = hwdata[MBXP_BOX_LSB +: 3];

	always_comb begin
		mbx_we = '0;
		mbx_clr = '0;
		if (wr_en && addr_r == OFS_MBX_PROG) begin
			mbx_we[prog_box] = 1'b1;
		end
		if (wr_en && addr_r == OFS_MBX_FLAG) begin
			mbx_clr = hwdata[NUM_MBX-1:0];
		end
	end

	for (genvar g = 0; g < NUM_MBX; g++) begin : g_mbx
		sbm_mailbox u_mbx (
			.hclk(hclk),
			.hresetn(hresetn),
			.rx(rxb.mbx),
			.prog_we(mbx_we[g]),
			.prog_id(hwdata[ID_W-1:0]),
			.flag_clr(mbx_clr[g]),
			.data(mbx_data[g]),
			.flag(mbx_flag[g]),
			.hit(mbx_hit[g])
		);
	end

	// Interrupt status: sticky, cleared by reading it, and a new event wins over the clear.
	always_comb begin
		ev_set = '0;
		ev_set[EV_SYNC_RX] = sync_hit;
		ev_set[EV_SYNC_TX] = tx_hs && tx_st_r == TX_SYNC;
		ev_set[EV_MBX_RX] = |mbx_hit;
		ev_set[EV_TX_DONE] = tx_hs && tx_st_r == TX_USER;
		ev_set[EV_TX_REJ] = usr_rej;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_r <= EV_RST;
		end else if (rd_en && addr_r == OFS_IRQ_STAT) begin
			ev_r <= ev_set;
		end else begin
			ev_r <= ev_r | ev_set;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_r <= EV_RST;
		end else if (wr_en && addr_r == OFS_IRQ_MASK) begin
			mask_r <= hwdata[NUM_EV-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(ev_r & mask_r);
		end
	end

	assign irq = irq_r;
endmodule

// File: verif/sbm_link_model.sv
// Behavioural peer card on the link: takes frames after a stall, sends frames on request.
`timescale 1ns/1ps
module sbm_link_model import sbm_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tx_valid,
	input wire logic [ID_W-1:0] tx_id,
	input wire logic [DATA_W-1:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [ID_W-1:0] rx_id,
	output logic [DATA_W-1:0] rx_data
);
	int stall = 0;
	int wait_cnt = 0;
	int n_frames = 0;
	logic [ID_W-1:0] last_id = '0;
	logic [DATA_W-1:0] last_data = '0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_id = '1;
		rx_data = '1;
	end
	// The stall lets the bench show that the block holds a frame for a slow peer without losing it.
	always @(posedge hclk) begin
		if (!hresetn) begin
			tx_ready <= 1'b0;
		end else if (tx_valid && tx_ready) begin
			n_frames <= n_frames + 1;
			last_id <= tx_id;
			last_data <= tx_data;
			tx_ready <= 1'b0;
			wait_cnt <= 0;
		end else if (tx_valid && wait_cnt >= stall) begin
			tx_ready <= 1'b1;
		end else if (tx_valid) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	// One peer only, so the sixteen-card limit holds; id 0 is sent only as a sync frame.
	task automatic send(input logic [ID_W-1:0] id, input logic [DATA_W-1:0] d);
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_id <= id;
		rx_data <= d;
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_id <= ~id;
		rx_data <= ~d;
	endtask
endmodule

// File: verif/sbm_chk.sv
// Port-level assertions for the sync bus mailbox top.
`timescale 1ns/1ps
module sbm_chk import sbm_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [ID_W-1:0] tx_id,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic is_master,
	input wire logic [1:0] rate_code,
	input wire logic bit_tick,
	input wire logic irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_taken;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_okay_resp: assert property (hresp == 1'b0) else $error("response not okay");
	chk_one_wait: assert property (s_taken |=> s_wait) else $error("wait state wrong");
	chk_rdata_hold: assert property (!hreadyout |-> $stable(hrdata)) else $error("hrdata moved");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id)
		&& $stable(tx_data)) else $error("frame not held");
	chk_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("frame not released");
	chk_sync_launch: assert property ($rose(tx_valid) && tx_id == SYNC_ID |->
		is_master && rate_code != RATE_250K) else $error("sync frame not allowed");
	chk_reset_state: assert property ($rose(hresetn) |-> !is_master &&
		rate_code == RATE_1M && !tx_valid && !irq) else $error("reset state wrong");
	chk_rate_legal: assert property (rate_code != RATE_BAD) else $error("bad rate");
	chk_tick_pulse: assert property (bit_tick |=> !bit_tick) else $error("tick too long");
endmodule
bind sbm_top sbm_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data),
	.is_master(is_master), .rate_code(rate_code), .bit_tick(bit_tick), .irq(irq));

// File: verif/sync_bus_mailbox_bench.sv
// Self-checking bench for the sync bus mailbox block.
`timescale 1ns/1ps
module sync_bus_mailbox_bench import sbm_pkg::*;;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, planner_idle = 1;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = '0, rate_code;
	logic hreadyout, hresp, tx_valid, tx_ready, rx_valid, is_master, bit_tick, irq;
	logic [ID_W-1:0] tx_id, rx_id;
	logic [DATA_W-1:0] tx_data, rx_data;
	int n_errors = 0, cmp_count = 0, n;
	int bits [3] = '{BIT_CYC_1M, BIT_CYC_500K, BIT_CYC_250K};
	logic [ID_W-1:0] ids [2] = '{11'h001, 11'h7ff};
	initial forever #2.5 hclk = ~hclk;
	sbm_top #(.SAMPLE_CYCLES(50)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.planner_idle(planner_idle), .tx_valid(tx_valid), .tx_id(tx_id), .tx_data(tx_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data),
		.is_master(is_master), .rate_code(rate_code), .bit_tick(bit_tick), .irq(irq));
	sbm_link_model lm (.hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid), .tx_id(tx_id),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id),
		.rx_data(rx_data));
	task automatic complete_run();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic fail(input string m);
		n_errors++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail($sformatf("got %h expected %h", got, exp));
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		k = 0;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		rd = hrdata;
		if (k >= 50) begin
			fail("bus hang");
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, '0);
		check(rd, exp);
	endtask
	task automatic wait_frame(input int cnt);
		int k;
		for (k = 0; k < 300 && lm.n_frames < cnt; k++) @(posedge hclk);
		if (k >= 300) begin
			fail("no frame");
			complete_run();
		end
	endtask
	// Measures the distance between two bit ticks in clocks.
	task automatic tick(input int r);
		int k;
		for (k = 0; k < 2000 && bit_tick !== 1'b1; k++) @(posedge hclk);
		@(posedge hclk);
		for (k = 1; k < 2000 && bit_tick !== 1'b1; k++) @(posedge hclk);
		check(k, bits[r]);
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_rd(OFS_CTRL, 0);
		chk_rd(OFS_MBX_FLAG, 0);
		chk_rd(8'h3c, 0);
		wr(OFS_CTRL, 1);
		check(is_master, 1);
		for (int r = 0; r < 3; r++) begin
			wr(OFS_CTRL, r << 2);
			check(rate_code, r);
			tick(r);
		end
		wr(OFS_CTRL, 32'hc);
		check(rate_code, 2);
		wr(OFS_SYNC_CFG, 32'h55);
		planner_idle <= 1'b0;
		wr(OFS_SYNC_CFG, 32'haa);
		planner_idle <= 1'b1;
		chk_rd(OFS_SYNC_CFG, 32'h55);
		wr(OFS_MTX_WORD, 32'h1234_5678);
		chk_rd(OFS_MTX_WORD, 32'h1234_5678);
		wr(OFS_CTRL, 3);
		wait_frame(1);
		check(lm.last_id, SYNC_ID);
		check(lm.last_data, 32'h1234_5678);
		wr(OFS_CTRL, 32'hb);
		chk_rd(OFS_STATUS, 32'h5);
		repeat (20) @(posedge hclk);
		n = lm.n_frames;
		repeat (200) @(posedge hclk);
		check(lm.n_frames, n);
		wr(OFS_CTRL, 0);
		check(is_master, 0);
		lm.send(SYNC_ID, 32'hcafe_0001);
		chk_rd(OFS_SRX_WORD, 32'hcafe_0001);
		chk_rd(OFS_IRQ_STAT, 32'h3);
		lm.stall = 5;
		foreach (ids[i]) begin
			n = lm.n_frames;
			wr(OFS_TX_ID, ids[i]);
			wr(OFS_TX_DATA, 32'hdead_0000 | ids[i]);
			wait_frame(n + 1);
			check(lm.last_id, ids[i]);
			check(lm.last_data, 32'hdead_0000 | ids[i]);
		end
		check(irq, 0);
		chk_rd(OFS_IRQ_STAT, 32'h8);
		wr(OFS_TX_ID, 0);
		wr(OFS_TX_DATA, 1);
		repeat (20) @(posedge hclk);
		check(lm.n_frames, n + 1);
		chk_rd(OFS_IRQ_STAT, 32'h10);
		wr(OFS_MBX_PROG, 32'h0001);
		wr(OFS_MBX_PROG, 32'h77ff);
		wr(OFS_IRQ_MASK, 32'h4);
		lm.send(11'h7ff, 32'h0bad_0007);
		repeat (2) @(posedge hclk);
		check(irq, 1);
		chk_rd(8'h5c, 32'h0bad_0007);
		chk_rd(OFS_MBX_FLAG, 32'h80);
		chk_rd(OFS_IRQ_STAT, 32'h4);
		repeat (2) @(posedge hclk);
		check(irq, 0);
		lm.send(11'h001, 32'h1);
		chk_rd(OFS_MBX_FLAG, 32'h81);
		wr(OFS_MBX_FLAG, 32'h80);
		chk_rd(OFS_MBX_FLAG, 32'h01);
		chk_rd(8'h40, 32'h1);
		complete_run();
	end
endmodule
